// *** logic/uwa_ctrl.sv ***
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module uwa_ctrl import uwa_pkg::*; #(
	parameter int EDGES = ABD_EDGES
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic rx, // Receive line
	input wire logic char_done, // Receive path finished a character
	output logic receive_flag, // Receive flag
	output logic rx_enable, // Shift path may assemble
	output logic [DIV_W-1:0] baud_div // Effective baud divider
);
	uwa_ctrl_t ctrl_r;
	uwa_state_t st_r;
	logic [15:0] div_r;
	logic [15:0] cnt_r;
	logic [3:0] edges_r;
	logic rx_q_r;
	logic fall;
	logic wr, hit;
	logic flag_clr;
	logic abd_done;

	assign wr = psel && penable && pwrite;
	assign hit = paddr == ADDR_CTRL || paddr == ADDR_STAT ||
		paddr == ADDR_DIV || paddr == ADDR_CNT;
	assign fall = rx_q_r && !rx;
	assign flag_clr = wr && paddr == ADDR_STAT && pwdata[0];
	assign abd_done = st_r == ST_ABD_RUN && fall &&
		edges_r == 4'(EDGES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q_r <= 1'b1;
		end else begin
			rx_q_r <= rx;
		end
	end

	// Hardware clears take priority: bit drop ends the mode it reports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= uwa_ctrl_t'(CTRL_RST[3:0]);
		end else begin
			if (wr && paddr == ADDR_CTRL) begin
				ctrl_r.sync_mode <= pwdata[BIT_SYNC];
				ctrl_r.wide_baud_divider_select <= pwdata[BIT_WIDE];
				ctrl_r.wake_on_edge_enable <= pwdata[BIT_WAKE];
				ctrl_r.baud_detect_enable <= pwdata[BIT_ABD];
			end
			if (st_r == ST_WAKE && fall) begin
				ctrl_r.wake_on_edge_enable <= 1'b0;
			end
			if (abd_done) begin
				ctrl_r.baud_detect_enable <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_NORMAL;
			edges_r <= 4'h0;
			cnt_r <= 16'h0000;
		end else begin
			case (st_r)
			ST_NORMAL: begin
				if (!ctrl_r.sync_mode && ctrl_r.baud_detect_enable) begin
					st_r <= ST_ABD;
				end else if (!ctrl_r.sync_mode &&
					ctrl_r.wake_on_edge_enable) begin
					st_r <= ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (fall || !ctrl_r.wake_on_edge_enable ||
					ctrl_r.sync_mode) begin
					st_r <= ST_NORMAL;
				end
			end
			ST_ABD: begin
				edges_r <= 4'h0;
				cnt_r <= 16'h0000;
				if (!ctrl_r.baud_detect_enable || ctrl_r.sync_mode) begin
					st_r <= ST_NORMAL;
				end else if (fall) begin
					// Arming edge counts, so the span ends on edge EDGES
					st_r <= ST_ABD_RUN;
					edges_r <= 4'h1;
					cnt_r <= 16'h0001;
				end
			end
			ST_ABD_RUN: begin
				cnt_r <= cnt_r + 16'h0001;
				if (fall) begin
					edges_r <= edges_r + 4'h1;
				end
				if (abd_done || !ctrl_r.baud_detect_enable) begin
					st_r <= ST_NORMAL;
				end
			end
			default: st_r <= ST_NORMAL;
			endcase
		end
	end

	// Measured span covers eight bit times; divide for per-bit count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= DIV_RST;
		end else if (abd_done) begin
			div_r <= cnt_r >> 3;
		end else if (wr && paddr == ADDR_DIV) begin
			div_r <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_div <= 16'h0000;
			rx_enable <= 1'b0;
		end else begin
			baud_div <= ctrl_r.wide_baud_divider_select ? div_r :
				{8'h00, div_r[7:0]};
			rx_enable <= st_r == ST_NORMAL;
		end
	end

	// Set wins over a same-cycle software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_flag <= 1'b0;
		end else if ((st_r == ST_WAKE && fall) ||
			(st_r == ST_NORMAL && char_done)) begin
			receive_flag <= 1'b1;
		end else if (flag_clr) begin
			receive_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				ADDR_CTRL: prdata <= {27'h0, ctrl_r.sync_mode,
					ctrl_r.wide_baud_divider_select, 1'b0,
					ctrl_r.wake_on_edge_enable,
					ctrl_r.baud_detect_enable};
				ADDR_STAT: prdata <= {28'h0, st_r == ST_ABD_RUN,
					st_r == ST_WAKE, rx_enable, receive_flag};
				ADDR_DIV: prdata <= {16'h0, div_r};
				ADDR_CNT: prdata <= {16'h0, cnt_r};
				default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	sequence wake_arm;
		st_r == ST_WAKE && fall;
	endsequence

	sequence abd_arm;
		st_r == ST_ABD && ctrl_r.baud_detect_enable &&
			!ctrl_r.sync_mode && fall;
	endsequence

	chk_wake_sets_flag: assert property (
		@(posedge pclk) disable iff (!presetn)
		wake_arm |=> receive_flag && !ctrl_r.wake_on_edge_enable)
		else $error("wake edge did not set flag or clear enable");
	chk_wake_no_rx: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_r == ST_WAKE |=> !rx_enable)
		else $error("receiver enabled while waiting for edge");
	chk_wake_return: assert property (
		@(posedge pclk) disable iff (!presetn)
		wake_arm |=> st_r == ST_NORMAL ##1 rx_enable)
		else $error("no return to normal after wake");
	chk_normal_rx: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_r == ST_NORMAL && char_done |=> receive_flag)
		else $error("character lost in normal mode");
	chk_wake_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_r.wake_on_edge_enable |=> st_r != ST_WAKE)
		else $error("edge wait without wake enable");
	chk_abd_arm: assert property (
		@(posedge pclk) disable iff (!presetn)
		abd_arm |=> st_r == ST_ABD_RUN && edges_r == 4'h1)
		else $error("arming edge did not start measurement");
	chk_abd_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		abd_done |=> !ctrl_r.baud_detect_enable && st_r == ST_NORMAL)
		else $error("baud detect enable not cleared");
	chk_div_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_r.baud_detect_enable && !wr |=> $stable(div_r))
		else $error("divider changed without detect");
	chk_abd_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_r.baud_detect_enable |=>
			st_r != ST_ABD && st_r != ST_ABD_RUN)
		else $error("measurement without detect enable");
	chk_div_width: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_r.wide_baud_divider_select ##1 1'b1 |->
		baud_div[15:8] == 8'h00)
		else $error("narrow divider has high bits");
	chk_sync_wake: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctrl_r.sync_mode && st_r == ST_NORMAL |=> st_r != ST_WAKE)
		else $error("wake entered in synchronous mode");
endmodule

// *** logic/uwa_pkg.sv ***
package uwa_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_DIV = 12'h008;
	localparam logic [11:0] ADDR_CNT = 12'h00C;
	localparam int BIT_ABD = 0;
	localparam int BIT_WAKE = 1;
	localparam int BIT_WIDE = 3;
	localparam int BIT_SYNC = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam int ABD_EDGES = 5;
	localparam int DIV_W = 16;
	typedef struct packed {
		logic sync_mode;
		logic wide_baud_divider_select;
		logic wake_on_edge_enable;
		logic baud_detect_enable;
	} uwa_ctrl_t;
	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0001,
		ST_WAKE = 4'b0010,
		ST_ABD = 4'b0100,
		ST_ABD_RUN = 4'b1000
	} uwa_state_t;
endpackage

// *** testbench/uwa_rx_src.sv ***
`timescale 1ns/1ps
module uwa_rx_src (
	input wire logic pclk, // System clock
	output logic rx // Line to receiver
);
	// Idle line is high, so it rests high between edges
	initial rx = 1'b1;
	task automatic falls(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge pclk);
			rx <= 1'b0;
			repeat (gap) @(posedge pclk);
			rx <= 1'b1;
		end
	endtask
endmodule

// *** testbench/uwa_ctrl_tb.sv ***
`timescale 1ns/1ps
module uwa_ctrl_tb import uwa_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, char_done, err;
	logic pready, pslverr, rx, receive_flag, rx_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [DIV_W-1:0] baud_div;
	int num_errors = 0;
	int n_checks = 0;
	int i;
	uwa_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx(rx), .char_done(char_done),
		.receive_flag(receive_flag), .rx_enable(rx_enable),
		.baud_div(baud_div));
	uwa_rx_src src (.pclk(pclk), .rx(rx));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// Starts just after an edge; two idle edges so outputs have settled
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, char_done} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(12'h010, 1'b0, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(ADDR_DIV, 1'b1, 32'h1234);
		chk("div8", 32'h34, {16'h0, baud_div});
		apb(ADDR_CTRL, 1'b1, 32'h8);
		chk("div16", 32'h1234, {16'h0, baud_div});
		apb(ADDR_CTRL, 1'b1, 32'h2);
		apb(ADDR_STAT, 1'b0, 32'h0);
		chk("waiting", 32'h4, rd & 32'h6);
		char_done <= 1'b1;
		@(posedge pclk);
		char_done <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("no char", 32'h0, {31'h0, receive_flag});
		src.falls(1, 4);
		for (i = 0; i < 40 && receive_flag !== 1'b1; i++) @(posedge pclk);
		chk("flag", 32'h1, {31'h0, receive_flag});
		apb(ADDR_CTRL, 1'b0, 32'h0);
		chk("wake clr", 32'h0, rd);
		chk("rx_en", 32'h1, {31'h0, rx_enable});
		apb(ADDR_STAT, 1'b1, 32'h1);
		chk("flag clr", 32'h0, {31'h0, receive_flag});
		char_done <= 1'b1;
		@(posedge pclk);
		char_done <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("char flag", 32'h1, {31'h0, receive_flag});
		apb(ADDR_STAT, 1'b1, 32'h1);
		chk("flag clr2", 32'h0, {31'h0, receive_flag});
		apb(ADDR_CTRL, 1'b1, 32'h12);
		src.falls(1, 4);
		chk("sync en", 32'h1, {31'h0, rx_enable});
		chk("sync flag", 32'h0, {31'h0, receive_flag});
		apb(ADDR_CTRL, 1'b1, 32'h1);
		src.falls(5, 8);
		for (i = 0; i < 8; i++) begin
			apb(ADDR_CTRL, 1'b0, 32'h0);
			if (rd[BIT_ABD] === 1'b0) break;
		end
		chk("abd clr", 32'h0, rd);
		chk("abd div", 32'h8, {16'h0, baud_div});
		src.falls(5, 4);
		chk("div kept", 32'h8, {16'h0, baud_div});
		report_and_stop();
	end
endmodule
